// [hdl/iopci_pkg.sv]
package iopci_pkg;
  // Register addresses on the device bus (4-bit address)
  localparam logic [3:0] ADDR_AUX_CTRL     = 4'h4;  // write: auxiliary_control
  localparam logic [3:0] ADDR_CHANGE_CAP   = 4'h4;  // read: input_change_capture
  localparam logic [3:0] ADDR_IRQ_MASK     = 4'h5;  // write: interrupt_enable_mask
  localparam logic [3:0] ADDR_IRQ_FLAGS    = 4'h5;  // read: interrupt_flags
  localparam logic [3:0] ADDR_OUT_SET      = 4'hE;  // write: output_set_strobe
  localparam logic [3:0] ADDR_OUT_CLR      = 4'hF;  // write: output_clear_strobe

  // Reset values
  localparam logic [7:0] RST_BYTE          = 8'h00;
  localparam logic [3:0] RST_NIBBLE        = 4'h0;

  // Auxiliary control field positions
  localparam int         AUX_BAUD_SET_BIT  = 7;
  localparam int         AUX_CT_MSB        = 6;
  localparam int         AUX_CT_LSB        = 4;
  localparam int         AUX_CT_TIMER_BIT  = 6;

  // Interrupt flag bit positions
  localparam int         FLAG_INPUT_CHANGE = 7;
  localparam int         FLAG_BRK_B        = 6;
  localparam int         FLAG_RX_B         = 5;
  localparam int         FLAG_TX_B         = 4;
  localparam int         FLAG_CTR_READY    = 3;
  localparam int         FLAG_BRK_A        = 2;
  localparam int         FLAG_RX_A         = 1;
  localparam int         FLAG_TX_A         = 0;

  // Counter/timer clock source selection
  typedef enum logic [2:0] {
    IOPCI_SRC_PIN_TWO,
    IOPCI_SRC_PIN_TWO_DIV16,
    IOPCI_SRC_TX_A,
    IOPCI_SRC_TX_B,
    IOPCI_SRC_CRYSTAL,
    IOPCI_SRC_CRYSTAL_DIV16
  } iopci_ct_src_t;
endpackage : iopci_pkg

// [hdl/iopci_port.sv]
`timescale 1ns/1ps
// Operation
// - Each output pin is the inverse of its output latch bit.
// - Set strobe write sets latch bits written as one.
// - Clear strobe write clears latch bits written as one.
// - Auxiliary bit 7 selects the baud-rate set for both channels.
// - Codes 000-011 select counter mode with four documented clock sources.
// - Codes 100-111 select timer mode, square wave, four clock sources.
// - Auxiliary bits 3..0 enable each pin change onto input-change flag.
// - Capture bits 7..4 set on change of input pins 3..0.
// - Reading capture register clears change bits and input-change flag.
// - Capture bits 3..0 return the synchronised, glitch-filtered input pin levels.
// - Interrupt output low when any flag and its mask bit are set.
// - Flag reads return unmasked status regardless of mask.
// - Interrupt flags clear to zero on reset.
// - Eight flags: input change, break B, rx B, tx B, counter, break A, rx A, tx A.
// - Mask bit one enables its flag onto interrupt output.
module iopci_port
  import iopci_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic [3:0] input_pins,
  input  wire logic       brk_b_flag,
  input  wire logic       rx_b_irq_flag,
  input  wire logic       tx_b_irq_flag,
  input  wire logic       ctr_ready_flag,
  input  wire logic       brk_a_flag,
  input  wire logic       rx_a_irq_flag,
  input  wire logic       tx_a_irq_flag,
  output logic      [7:0] output_pins,
  output logic            baud_set_sel,
  output logic            ct_timer_mode,
  output iopci_ct_src_t   ct_clock_src,
  output logic            irq_out_low
);

  logic [7:0]    output_latch;
  logic [7:0]    next_output_latch;
  logic [7:0]    auxiliary_control;
  logic [7:0]    next_auxiliary_control;
  logic [7:0]    interrupt_enable_mask;
  logic [7:0]    next_interrupt_enable_mask;
  logic [7:0]    interrupt_flags;
  logic [7:0]    next_interrupt_flags;
  logic [3:0]    change_bits;
  logic [3:0]    next_change_bits;
  logic [3:0]    pin_meta;
  logic [3:0]    pin_sync;
  logic [3:0]    pin_stable;
  logic [3:0]    next_pin_stable;
  logic [3:0]    pin_seen;
  logic [3:0]    change_evt;
  logic [7:0]    next_rdata;
  logic          next_irq_out_low;
  logic [7:0]    next_output_pins;
  iopci_ct_src_t next_ct_clock_src;
  logic          cap_read;

  // Decode of write strobe qualified by 4-bit address match, used for every writable register
  function automatic logic wr_hit(input logic [3:0] a, input logic [3:0] target,
                                  input logic stb);
    wr_hit = stb && (a == target);
  endfunction : wr_hit

  // Map auxiliary counter/timer code to its clock source
  function automatic iopci_ct_src_t ct_source(input logic [2:0] code);
    case (code)
      3'h0:    ct_source = IOPCI_SRC_PIN_TWO;
      3'h1:    ct_source = IOPCI_SRC_TX_A;
      3'h2:    ct_source = IOPCI_SRC_TX_B;
      3'h3:    ct_source = IOPCI_SRC_CRYSTAL_DIV16;
      3'h4:    ct_source = IOPCI_SRC_PIN_TWO;
      3'h5:    ct_source = IOPCI_SRC_PIN_TWO_DIV16;
      3'h6:    ct_source = IOPCI_SRC_CRYSTAL;
      default: ct_source = IOPCI_SRC_CRYSTAL_DIV16;
    endcase
  endfunction : ct_source

  assign cap_read = rd_stb && (addr == ADDR_CHANGE_CAP);

  // Two-flop synchroniser; first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= RST_NIBBLE;
      pin_sync <= RST_NIBBLE;
      pin_seen <= RST_NIBBLE;
    end else begin
      pin_meta <= input_pins;
      pin_sync <= pin_meta;
      pin_seen <= pin_sync;
    end
  end

  // Accept a level only after two equal synchronised samples; filters one-cycle glitches
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      always_comb begin
        next_pin_stable[g] = pin_stable[g];
        change_evt[g]      = 1'b0;
        if ((pin_sync[g] == pin_seen[g]) && (pin_seen[g] != pin_stable[g])) begin
          next_pin_stable[g] = pin_seen[g];
          change_evt[g]      = 1'b1;
        end
      end
    end
  endgenerate

  // Next-state for registers, flags and outputs
  always_comb begin
    next_output_latch = output_latch;
    if (wr_hit(addr, ADDR_OUT_SET, wr_stb)) begin
      next_output_latch = output_latch | wdata;
    end
    if (wr_hit(addr, ADDR_OUT_CLR, wr_stb)) begin
      next_output_latch = output_latch & ~wdata;
    end
    next_auxiliary_control = auxiliary_control;
    if (wr_hit(addr, ADDR_AUX_CTRL, wr_stb)) begin
      next_auxiliary_control = wdata;
    end
    next_interrupt_enable_mask = interrupt_enable_mask;
    if (wr_hit(addr, ADDR_IRQ_MASK, wr_stb)) begin
      next_interrupt_enable_mask = wdata;
    end
    // Clear on read first, then new events win over it
    next_change_bits = cap_read ? RST_NIBBLE : change_bits;
    next_change_bits = next_change_bits | change_evt;
    next_interrupt_flags = interrupt_flags;
    if (cap_read) begin
      next_interrupt_flags[FLAG_INPUT_CHANGE] = 1'b0;
    end
    if (|(next_change_bits & auxiliary_control[3:0] & ~(cap_read ? RST_NIBBLE : change_bits))
        || |(change_evt & auxiliary_control[3:0])) begin
      next_interrupt_flags[FLAG_INPUT_CHANGE] = 1'b1;
    end
    // Channel and counter sources mirror their levels
    next_interrupt_flags[FLAG_BRK_B]     = brk_b_flag;
    next_interrupt_flags[FLAG_RX_B]      = rx_b_irq_flag;
    next_interrupt_flags[FLAG_TX_B]      = tx_b_irq_flag;
    next_interrupt_flags[FLAG_CTR_READY] = ctr_ready_flag;
    next_interrupt_flags[FLAG_BRK_A]     = brk_a_flag;
    next_interrupt_flags[FLAG_RX_A]      = rx_a_irq_flag;
    next_interrupt_flags[FLAG_TX_A]      = tx_a_irq_flag;
    next_irq_out_low  = ~|(next_interrupt_flags & next_interrupt_enable_mask);
    next_output_pins  = ~next_output_latch;
    next_ct_clock_src = ct_source(next_auxiliary_control[AUX_CT_MSB:AUX_CT_LSB]);
    next_rdata = rdata;
    if (rd_stb) begin
      case (addr)
        ADDR_CHANGE_CAP: next_rdata = {change_bits, pin_stable};
        ADDR_IRQ_FLAGS:  next_rdata = interrupt_flags;
        default:         next_rdata = RST_BYTE;
      endcase
    end
  end

  // Register stage; latch and controls hold undefined-free reset values
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      output_latch          <= RST_BYTE;
      auxiliary_control     <= RST_BYTE;
      interrupt_enable_mask <= RST_BYTE;
      interrupt_flags       <= RST_BYTE;
      change_bits           <= RST_NIBBLE;
      pin_stable            <= RST_NIBBLE;
      rdata                 <= RST_BYTE;
      irq_out_low           <= 1'b1;
      output_pins           <= ~RST_BYTE;
      baud_set_sel          <= 1'b0;
      ct_timer_mode         <= 1'b0;
      ct_clock_src          <= IOPCI_SRC_PIN_TWO;
    end else begin
      output_latch          <= next_output_latch;
      auxiliary_control     <= next_auxiliary_control;
      interrupt_enable_mask <= next_interrupt_enable_mask;
      interrupt_flags       <= next_interrupt_flags;
      change_bits           <= next_change_bits;
      pin_stable            <= next_pin_stable;
      rdata                 <= next_rdata;
      irq_out_low           <= next_irq_out_low;
      output_pins           <= next_output_pins;
      baud_set_sel          <= next_auxiliary_control[AUX_BAUD_SET_BIT];
      ct_timer_mode         <= next_auxiliary_control[AUX_CT_TIMER_BIT];
      ct_clock_src          <= next_ct_clock_src;
    end
  end

  // Checks next to the logic
  a_pins_invert: assert property (@(posedge clk_sys) disable iff (rst)
    output_pins == ~output_latch) else $error("output pins not inverse of latch");
  a_set_strobe: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_stb && addr == ADDR_OUT_SET) |=> ((output_latch & $past(wdata)) == $past(wdata)))
    else $error("set strobe failed");
  a_clear_strobe: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_stb && addr == ADDR_OUT_CLR) |=> ((output_latch & $past(wdata)) == RST_BYTE))
    else $error("clear strobe failed");
  a_baud_select: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_stb && addr == ADDR_AUX_CTRL) |=> baud_set_sel == $past(wdata[AUX_BAUD_SET_BIT]))
    else $error("baud set select not updated");
  a_timer_mode: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_stb && addr == ADDR_AUX_CTRL && wdata[6:4] == 3'h5) |=>
    (ct_timer_mode && ct_clock_src == IOPCI_SRC_PIN_TWO_DIV16))
    else $error("timer mode source wrong");
  a_change_set: assert property (@(posedge clk_sys) disable iff (rst)
    (change_evt != RST_NIBBLE) |=> ((change_bits & $past(change_evt)) == $past(change_evt)))
    else $error("change not captured");
  a_read_clears: assert property (@(posedge clk_sys) disable iff (rst)
    (cap_read && change_evt == RST_NIBBLE) |=> (change_bits == RST_NIBBLE)
    && !interrupt_flags[FLAG_INPUT_CHANGE]) else $error("capture read did not clear");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
    irq_out_low == ~|(interrupt_flags & interrupt_enable_mask))
    else $error("interrupt output mismatch");
  a_enable_gate: assert property (@(posedge clk_sys) disable iff (rst)
    ((change_evt & auxiliary_control[3:0]) != RST_NIBBLE) |=> interrupt_flags[FLAG_INPUT_CHANGE])
    else $error("enabled change did not flag");
  a_flag_read: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_stb && addr == ADDR_IRQ_FLAGS) |=> rdata == $past(interrupt_flags))
    else $error("flag read not unmasked status");
endmodule : iopci_port

// [tb/iopci_pin_model.sv]
`timescale 1ns/1ps
// External pin source; edges land off the clock grid like a real async input
module iopci_pin_model (
  input  wire logic [3:0] level_req,
  output logic      [3:0] input_pins
);
  // Idle pins sit low from time zero
  initial begin
    input_pins = 4'h0;
  end
  // Transport delay keeps even the shortest pulse, so filtering is really tested
  always @(level_req) begin
    input_pins <= #1.3 level_req;
  end
endmodule : iopci_pin_model

// [tb/io_port_change_interrupt_tb.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module io_port_change_interrupt_tb;
  import iopci_pkg::*;
  logic          clk_sys, rst, wr_stb, rd_stb, rd_seen;
  logic [3:0]    addr, level_req, input_pins;
  logic [3:0]    en = 4'h5;
  logic [7:0]    wdata, rdata, output_pins, latch, r, mask, exp;
  logic [6:0]    chan;
  logic          baud_set_sel, ct_timer_mode, irq_out_low;
  iopci_ct_src_t ct_clock_src;
  integer        seed = 50378;
  int            fail_count, compares;
  logic [7:0]    exp_q[$];
  iopci_ct_src_t src_tab[8] = '{IOPCI_SRC_PIN_TWO, IOPCI_SRC_TX_A, IOPCI_SRC_TX_B,
    IOPCI_SRC_CRYSTAL_DIV16, IOPCI_SRC_PIN_TWO, IOPCI_SRC_PIN_TWO_DIV16,
    IOPCI_SRC_CRYSTAL, IOPCI_SRC_CRYSTAL_DIV16};

  iopci_port uut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .input_pins(input_pins),
    .brk_b_flag(chan[6]), .rx_b_irq_flag(chan[5]), .tx_b_irq_flag(chan[4]),
    .ctr_ready_flag(chan[3]), .brk_a_flag(chan[2]), .rx_a_irq_flag(chan[1]),
    .tx_a_irq_flag(chan[0]), .output_pins(output_pins), .baud_set_sel(baud_set_sel),
    .ct_timer_mode(ct_timer_mode), .ct_clock_src(ct_clock_src), .irq_out_low(irq_out_low));
  iopci_pin_model pins (.level_req(level_req), .input_pins(input_pins));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask : wr

  // Expected data is queued before the strobe so the monitor finds it waiting
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
  endtask : rd

  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask : settle

  // Read data is registered, so it is judged half a cycle after the taking edge
  always @(posedge clk_sys) rd_seen <= rd_stb & ~rst;
  always @(negedge clk_sys) begin
    if (rd_seen && exp_q.size() > 0) begin
      exp = exp_q.pop_front();
      `CHK(rdata, exp)
    end else if (rd_seen) begin
      // A read with nothing expected is a bench fault, not a pass
      fail_count++;
      $display("[FAIL] %0t read with no expected value", $time);
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end

  initial begin
    rst = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 4'h0; wdata = 8'h00;
    level_req = 4'h0; chan = 7'h00; latch = 8'h00;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    `CHK(output_pins, 8'hFF)
    `CHK(irq_out_low, 1'b1)
    rd(ADDR_IRQ_FLAGS, 8'h00);
    rd(4'h3, 8'h00);
    settle();
    $display("test reset done");
    // Random set and clear strobes against a shadow latch
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      wr(i[0] ? ADDR_OUT_CLR : ADDR_OUT_SET, r);
      latch = i[0] ? (latch & ~r) : (latch | r);
      settle();
      `CHK(output_pins, ~latch)
    end
    // A write to an unused address must leave the latch alone
    wr(4'h3, 8'($random(seed)));
    settle();
    `CHK(output_pins, ~latch)
    $display("test output strobes done");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_AUX_CTRL, {c[3], c[2:0], 4'h0});
      settle();
      `CHK(baud_set_sel, c[3])
      `CHK(ct_timer_mode, c[2])
      `CHK(ct_clock_src, src_tab[c[2:0]])
    end
    $display("test aux modes done");
    // Pins 0 and 2 enabled, 1 and 3 only captured
    wr(ADDR_IRQ_MASK, 8'h80);
    wr(ADDR_AUX_CTRL, {4'h0, en});
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_sys);
      level_req <= level_req ^ (4'h1 << p);
      repeat (12) @(negedge clk_sys);
      `CHK(irq_out_low, ~en[p])
      rd(ADDR_IRQ_FLAGS, {en[p], 7'h00});
      rd(ADDR_CHANGE_CAP, {4'h1 << p, level_req});
      rd(ADDR_IRQ_FLAGS, 8'h00);
      settle();
      `CHK(irq_out_low, 1'b1)
    end
    // One-cycle glitch must leave no change behind
    @(posedge clk_sys);
    level_req <= level_req ^ 4'h1;
    @(posedge clk_sys);
    level_req <= level_req ^ 4'h1;
    repeat (12) @(negedge clk_sys);
    rd(ADDR_CHANGE_CAP, {4'h0, level_req});
    settle();
    // Pin 2 change lands on the capture read edge; it must survive that read
    @(posedge clk_sys);
    level_req <= level_req ^ 4'h4;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_CHANGE_CAP, {4'h0, 4'hF});
    rd(ADDR_IRQ_FLAGS, 8'h80);
    rd(ADDR_CHANGE_CAP, {4'h4, 4'hB});
    settle();
    `CHK(irq_out_low, 1'b1)
    $display("test input change done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      chan <= 7'($random(seed));
      mask = (i == 0) ? 8'h00 : 8'($random(seed));
      wr(ADDR_IRQ_MASK, mask);
      settle();
      `CHK(irq_out_low, ~|({1'b0, chan} & mask))
      rd(ADDR_IRQ_FLAGS, {1'b0, chan});
      settle();
    end
    $display("test flags and mask done");
    if (exp_q.size() != 0) fail_count++;
    test_done();
  end
endmodule : io_port_change_interrupt_tb
